// file: upb_board_model.sv
`timescale 1ns/1ps

module upb_board_model (
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    input wire logic [3:0] ext_val,
    output logic [3:0] pin_in
);
    // strong external source wins only where the device releases the pad
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_val[i];
        end
    end
endmodule

// file: upb_pin_cell.sv
`timescale 1ns/1ps

module upb_pin_cell (
    input logic clock,
    input logic reset_n,
    input logic pin_in,
    input logic latch_bit,
    input logic analog_sel,
    input logic direction,
    input logic route_sel,
    input logic periph_bit,
    input logic analog_out_en,
    output logic pad_out,
    output logic pad_oe,
    output logic level
);

    upb_pkg::upb_cell_state_type state;
    upb_pkg::upb_cell_state_type next_state;

    // next state of the pad and of the input path
    always_comb begin
        next_state = state;
        // sync1 is read by sync2 alone, so metastability never fans out
        next_state.sync1 = pin_in;
        next_state.sync2 = state.sync1;
        // analog mode shuts the input buffer, digital reads see zero
        next_state.level = state.sync2 & ~analog_sel; // R7 R8 R11
        if (analog_out_en) begin
            // an analog output owns the pad, digital drive steps back
            next_state.pad_out = 1'b0; // R2
            next_state.pad_oe = 1'b0;
        end else begin
            // latch by default, peripheral when routed here
            next_state.pad_out = route_sel ? periph_bit : latch_bit; // R1 R2
            // analog select is left out on purpose: output keeps working
            next_state.pad_oe = ~direction; // R3 R12
        end
    end

    // register the cell state
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state <= upb_pkg::CELL_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign pad_out = state.pad_out;
    assign pad_oe = state.pad_oe;
    assign level = state.level;

    analog_gate_a: assert property (@(posedge clock) disable iff (!reset_n) // R11
        analog_sel |=> !level)
        else $error("analog pin read back non-zero");

    digital_follow_a: assert property (@(posedge clock) disable iff (!reset_n) // R8
        !analog_sel && $past(reset_n) && $past(reset_n, 2) |=> level == $past(pin_in, 3))
        else $error("digital pin level not followed");

    analog_drive_a: assert property (@(posedge clock) disable iff (!reset_n) // R3
        analog_sel && !direction && !analog_out_en |=> pad_oe)
        else $error("analog select blocked digital drive");

    drive_off_a: assert property (@(posedge clock) disable iff (!reset_n) // R12
        direction |=> !pad_oe)
        else $error("pad driven while direction is input");

    source_sel_a: assert property (@(posedge clock) disable iff (!reset_n) // R2
        route_sel && !analog_out_en |=> pad_out == $past(periph_bit))
        else $error("routed peripheral not on pad");

endmodule

// file: upb_pkg.sv
package upb_pkg;

    // pin count and where the upper pins sit inside the 8-bit register
    localparam int PIN_COUNT = 4;
    localparam int UPPER_LSB = 4;
    localparam int UPPER_MSB = 7;

    // byte addresses of the register words on the bus
    localparam logic [11:0] LATCH_OFFSET = 12'h000;
    localparam logic [11:0] ANALOG_OFFSET = 12'h004;
    localparam logic [11:0] LEVEL_OFFSET = 12'h008;
    localparam logic [11:0] DIRECTION_OFFSET = 12'h00c;
    localparam logic [11:0] ROUTE_OFFSET = 12'h010;

    // reset values of the writable fields
    localparam logic [3:0] LATCH_RESET = 4'h0;
    localparam logic [3:0] ANALOG_RESET = 4'hf;
    localparam logic [3:0] DIRECTION_RESET = 4'hf;
    localparam logic [3:0] ROUTE_RESET = 4'h0;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } upb_apb_req_type;

    // apb answer back to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } upb_apb_rsp_type;

    // whole state of the top module
    typedef struct packed {
        logic [3:0] latch;
        logic [3:0] analog;
        logic [3:0] direction;
        logic [3:0] route;
        upb_apb_rsp_type rsp;
    } upb_top_state_type;

    // whole state of one pin cell
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic level;
        logic pad_out;
        logic pad_oe;
    } upb_cell_state_type;

    localparam upb_top_state_type TOP_RESET = '{
        latch: LATCH_RESET,
        analog: ANALOG_RESET,
        direction: DIRECTION_RESET,
        route: ROUTE_RESET,
        rsp: '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0}
    };

    localparam upb_cell_state_type CELL_RESET = '{
        sync1: 1'b0, sync2: 1'b0, level: 1'b0, pad_out: 1'b0, pad_oe: 1'b0
    };

endpackage

// file: upb_port_top.sv
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps

// Operation
// R1: pins drive own latch after every reset
// R2: routed peripheral or analog output replaces latch
// R3: analog select keeps digital output drive
// R4: four latch bits at positions 7 to 4
// R5: port data writes land in latch
// R6: port data reads return live pin levels
// R7: analog select one disables digital input
// R8: analog select zero gives digital I/O
// R9: bits 3 to 0 read zero, ignore writes
// R10: software sets direction input for analog pins
// R11: analog pins always read digital zero
// R12: driver enabled only when direction is output

module upb_port_top (
    input logic clock,
    input logic reset_n,
    input upb_pkg::upb_apb_req_type apb_req,
    output upb_pkg::upb_apb_rsp_type apb_rsp,
    input logic [3:0] pin_in,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe,
    input logic [3:0] periph_out,
    input logic [3:0] analog_out_en,
    output logic [3:0] digital_in
);

    upb_pkg::upb_top_state_type state;
    upb_pkg::upb_top_state_type next_state;

    // bus decode helpers, all filled by the one combinational process
    logic access;
    logic complete;
    logic mapped;
    logic [11:0] word_addr;
    logic [31:0] read_word;
    logic [3:0] upper_wdata;

    // gated levels of the four pins, from the pin cells
    logic [3:0] pin_level;

    // next state: apb slave and register file
    always_comb begin
        next_state = state;
        access = apb_req.psel && apb_req.penable;
        // the access edge that the master samples with pready high
        complete = access && state.rsp.pready;
        // low address bits ignored, every register is one aligned word
        word_addr = {apb_req.paddr[11:2], 2'b00};
        upper_wdata = apb_req.pwdata[upb_pkg::UPPER_MSB:upb_pkg::UPPER_LSB];
        read_word = 32'h0000_0000;
        mapped = 1'b1;
        // read mux, unused low bits stay zero
        unique case (word_addr)
            upb_pkg::LATCH_OFFSET: begin
                read_word[upb_pkg::UPPER_MSB:upb_pkg::UPPER_LSB] = state.latch; // R4 R9
            end
            upb_pkg::ANALOG_OFFSET: begin
                read_word[upb_pkg::UPPER_MSB:upb_pkg::UPPER_LSB] = state.analog; // R9
            end
            upb_pkg::LEVEL_OFFSET: begin
                // live pins, never the latch; analog pins already read zero
                read_word[upb_pkg::UPPER_MSB:upb_pkg::UPPER_LSB] = pin_level; // R6 R11
            end
            upb_pkg::DIRECTION_OFFSET: begin
                read_word[upb_pkg::UPPER_MSB:upb_pkg::UPPER_LSB] = state.direction;
            end
            upb_pkg::ROUTE_OFFSET: begin
                read_word[upb_pkg::UPPER_MSB:upb_pkg::UPPER_LSB] = state.route;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase

        // pready is a one-cycle pulse: one wait state on every access
        next_state.rsp.pready = 1'b0;
        if (access && !state.rsp.pready) begin
            next_state.rsp.pready = 1'b1;
            next_state.rsp.pslverr = !mapped;
            next_state.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : read_word;
        end

        // writes take effect only at the completing edge, lane 0 only
        if (complete && apb_req.pwrite && mapped && apb_req.pstrb[0]) begin
            unique case (word_addr)
                upb_pkg::LATCH_OFFSET: begin
                    // only bits 7 to 4 exist, bits 3 to 0 are dropped
                    next_state.latch = upper_wdata; // R4 R9
                end
                upb_pkg::LEVEL_OFFSET: begin
                    // a port write never touches the pins directly
                    next_state.latch = upper_wdata; // R5
                end
                upb_pkg::ANALOG_OFFSET: begin
                    next_state.analog = upper_wdata; // R7 R8 R9
                end
                upb_pkg::DIRECTION_OFFSET: begin
                    // software should leave analog pins as inputs
                    next_state.direction = upper_wdata; // R10 R12
                end
                upb_pkg::ROUTE_OFFSET: begin
                    next_state.route = upper_wdata; // R2
                end
                default: begin
                    next_state.latch = state.latch;
                end
            endcase
        end
    end

    // register the top state; reset hands every pin back to its latch
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state <= upb_pkg::TOP_RESET; // R1
        end else begin
            state <= next_state;
        end
    end

    assign apb_rsp = state.rsp;

    // one cell per pin; the cell registers pad drive and input level
    for (genvar i = 0; i < upb_pkg::PIN_COUNT; i++) begin : g_pin
        upb_pin_cell u_cell (
            .clock(clock),
            .reset_n(reset_n),
            .pin_in(pin_in[i]),
            .latch_bit(state.latch[i]),
            .analog_sel(state.analog[i]),
            .direction(state.direction[i]),
            .route_sel(state.route[i]),
            .periph_bit(periph_out[i]),
            .analog_out_en(analog_out_en[i]),
            .pad_out(pin_out[i]),
            .pad_oe(pin_oe[i]),
            .level(pin_level[i])
        );
    end

    // peripherals see the same gated levels as software
    assign digital_in = pin_level;

    reset_latch_a: assert property (@(posedge clock) // R1
        !reset_n |=> state.route == upb_pkg::ROUTE_RESET)
        else $error("peripheral route active after reset");

    reset_drive_a: assert property (@(posedge clock) disable iff (!reset_n) // R1
        $rose(reset_n) && analog_out_en == 4'h0 ##1 analog_out_en == 4'h0
        |=> pin_out == $past(state.latch))
        else $error("pins not driven from latch after reset");

    latch_write_a: assert property (@(posedge clock) disable iff (!reset_n) // R4
        complete && apb_req.pwrite && apb_req.pstrb[0]
        && word_addr == upb_pkg::LATCH_OFFSET
        |=> state.latch == $past(apb_req.pwdata[7:4]))
        else $error("latch write lost");

    port_write_a: assert property (@(posedge clock) disable iff (!reset_n) // R5
        complete && apb_req.pwrite && apb_req.pstrb[0]
        && word_addr == upb_pkg::LEVEL_OFFSET
        |=> state.latch == $past(apb_req.pwdata[7:4]))
        else $error("port write did not reach latch");

    port_read_a: assert property (@(posedge clock) disable iff (!reset_n) // R6
        access && !state.rsp.pready && !apb_req.pwrite
        && word_addr == upb_pkg::LEVEL_OFFSET
        |=> apb_rsp.pready && apb_rsp.prdata[7:4] == $past(pin_level))
        else $error("port read not live pin level");

    low_bits_a: assert property (@(posedge clock) disable iff (!reset_n) // R9
        apb_rsp.pready |-> apb_rsp.prdata[3:0] == 4'h0
        && apb_rsp.prdata[31:8] == 24'h00_0000)
        else $error("unimplemented bits read non-zero");

    analog_read_a: assert property (@(posedge clock) disable iff (!reset_n) // R11
        state.analog == 4'hf ##1 state.analog == 4'hf |=> digital_in == 4'h0)
        else $error("analog pins visible to digital reads");

    ready_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
        apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready held beyond one cycle");

    unmapped_a: assert property (@(posedge clock) disable iff (!reset_n)
        access && !state.rsp.pready && !mapped |=> apb_rsp.pslverr && apb_rsp.pready)
        else $error("unmapped address not flagged");

    // latch read-back shows the latch, never the pins
    latch_read_a: assert property (@(posedge clock) disable iff (!reset_n) // R4
        access && !state.rsp.pready && !apb_req.pwrite
        && word_addr == upb_pkg::LATCH_OFFSET
        |=> apb_rsp.prdata[7:4] == $past(state.latch))
        else $error("latch read-back wrong");

    // analog select word reads back as written
    analog_word_a: assert property (@(posedge clock) disable iff (!reset_n) // R7
        access && !state.rsp.pready && !apb_req.pwrite
        && word_addr == upb_pkg::ANALOG_OFFSET
        |=> apb_rsp.prdata[7:4] == $past(state.analog))
        else $error("analog select read-back wrong");

    // direction word reads back as written
    direction_word_a: assert property (@(posedge clock) disable iff (!reset_n) // R12
        access && !state.rsp.pready && !apb_req.pwrite
        && word_addr == upb_pkg::DIRECTION_OFFSET
        |=> apb_rsp.prdata[7:4] == $past(state.direction))
        else $error("direction read-back wrong");

    // route word reads back as written
    route_word_a: assert property (@(posedge clock) disable iff (!reset_n) // R2
        access && !state.rsp.pready && !apb_req.pwrite
        && word_addr == upb_pkg::ROUTE_OFFSET
        |=> apb_rsp.prdata[7:4] == $past(state.route))
        else $error("route read-back wrong");

    // analog pins read zero through the port word as well
    level_hide_a: assert property (@(posedge clock) disable iff (!reset_n) // R11
        access && !state.rsp.pready && !apb_req.pwrite
        && word_addr == upb_pkg::LEVEL_OFFSET
        |=> (apb_rsp.prdata[7:4] & $past(state.analog)) == 4'h0)
        else $error("analog pin visible in port read");

    // analog select write lands at the completing edge
    analog_write_a: assert property (@(posedge clock) disable iff (!reset_n) // R7
        complete && apb_req.pwrite && apb_req.pstrb[0]
        && word_addr == upb_pkg::ANALOG_OFFSET
        |=> state.analog == $past(apb_req.pwdata[7:4]))
        else $error("analog select write lost");

    // direction write lands at the completing edge
    direction_write_a: assert property (@(posedge clock) disable iff (!reset_n) // R12
        complete && apb_req.pwrite && apb_req.pstrb[0]
        && word_addr == upb_pkg::DIRECTION_OFFSET
        |=> state.direction == $past(apb_req.pwdata[7:4]))
        else $error("direction write lost");

    // route write lands at the completing edge
    route_write_a: assert property (@(posedge clock) disable iff (!reset_n) // R2
        complete && apb_req.pwrite && apb_req.pstrb[0]
        && word_addr == upb_pkg::ROUTE_OFFSET
        |=> state.route == $past(apb_req.pwdata[7:4]))
        else $error("route write lost");

    // a write without the lane 0 strobe changes nothing
    strobe_ignore_a: assert property (@(posedge clock) disable iff (!reset_n) // R5
        complete && apb_req.pwrite && !apb_req.pstrb[0]
        |=> $stable(state.latch) && $stable(state.analog)
        && $stable(state.direction) && $stable(state.route))
        else $error("write without lane 0 strobe took effect");

    // a refused write leaves every field alone
    unmapped_keep_a: assert property (@(posedge clock) disable iff (!reset_n) // R9
        complete && apb_req.pwrite && !mapped
        |=> $stable(state.latch) && $stable(state.analog)
        && $stable(state.direction) && $stable(state.route))
        else $error("unmapped write changed a register");

    // the wait-state edge must not write early
    early_write_a: assert property (@(posedge clock) disable iff (!reset_n) // R5
        access && !state.rsp.pready
        |=> $stable(state.latch) && $stable(state.analog)
        && $stable(state.direction) && $stable(state.route))
        else $error("write took effect before completion");

    // every access is answered after exactly one wait state
    ready_after_a: assert property (@(posedge clock) disable iff (!reset_n)
        access && !state.rsp.pready |=> apb_rsp.pready)
        else $error("access not answered after one wait state");

    // no answer appears without an access
    no_answer_a: assert property (@(posedge clock) disable iff (!reset_n)
        !access |=> !apb_rsp.pready)
        else $error("pready without an access");

    // writes answer with zero read data
    write_data_a: assert property (@(posedge clock) disable iff (!reset_n)
        access && !state.rsp.pready && apb_req.pwrite |=> apb_rsp.prdata == 32'h0000_0000)
        else $error("write answered with read data");

    // mapped words never raise the error flag
    mapped_ok_a: assert property (@(posedge clock) disable iff (!reset_n)
        access && !state.rsp.pready && mapped |=> !apb_rsp.pslverr)
        else $error("mapped access flagged as error");

    // answer data stays put between answers
    answer_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        !(access && !state.rsp.pready)
        |=> $stable(apb_rsp.prdata) && $stable(apb_rsp.pslverr))
        else $error("answer changed without an access");

    // reset restores the latch, analog select and direction fields
    reset_fields_a: assert property (@(posedge clock) // R1
        !reset_n |=> state.latch == upb_pkg::LATCH_RESET
        && state.analog == upb_pkg::ANALOG_RESET
        && state.direction == upb_pkg::DIRECTION_RESET)
        else $error("register field not at reset value");

    // pads released and bus quiet while reset is low
    reset_pads_a: assert property (@(posedge clock) // R1
        !reset_n |=> pin_oe == 4'h0 && digital_in == 4'h0 && !apb_rsp.pready)
        else $error("outputs active during reset");

    // unrouted pins follow their latch one edge later
    latch_drive_a: assert property (@(posedge clock) disable iff (!reset_n) // R1
        reset_n |=> ((pin_out ^ $past(state.latch)) & ~$past(state.route)
        & ~$past(analog_out_en)) == 4'h0)
        else $error("unrouted pin not driven from latch");

    // routed pins follow the peripheral one edge later
    routed_drive_a: assert property (@(posedge clock) disable iff (!reset_n) // R2
        state.route != 4'h0 |=> ((pin_out ^ $past(periph_out)) & $past(state.route)
        & ~$past(analog_out_en)) == 4'h0)
        else $error("routed pin not driven from peripheral");

    // an analog output takes the pad from digital drive
    analog_release_a: assert property (@(posedge clock) disable iff (!reset_n) // R2
        analog_out_en != 4'h0 |=> (pin_oe & $past(analog_out_en)) == 4'h0)
        else $error("pad driven under analog output");

    // input pins are never driven
    input_release_a: assert property (@(posedge clock) disable iff (!reset_n) // R12
        state.direction != 4'h0 |=> (pin_oe & $past(state.direction)) == 4'h0)
        else $error("input pin driven");

    // enable follows direction where no analog output is on, analog select has no say
    output_enable_a: assert property (@(posedge clock) disable iff (!reset_n) // R3
        reset_n |=> ((pin_oe ^ ~$past(state.direction))
        & ~$past(analog_out_en)) == 4'h0)
        else $error("pad enable not set by direction");

    // analog pins never reach the peripherals
    level_gate_a: assert property (@(posedge clock) disable iff (!reset_n) // R7
        state.analog != 4'h0 |=> (digital_in & $past(state.analog)) == 4'h0)
        else $error("analog pin level reached peripherals");

    // digital pins reach the peripherals three edges after the pin
    digital_pass_a: assert property (@(posedge clock) disable iff (!reset_n) // R8
        state.analog == 4'h0 && $past(reset_n) && $past(reset_n, 2)
        |=> digital_in == $past(pin_in, 3))
        else $error("digital pin level not passed on");

endmodule

// file: upper_port_latch_analog_select_tb.sv
`timescale 1ns/1ps

module upper_port_latch_analog_select_tb;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    upb_pkg::upb_apb_req_type req = '0;
    upb_pkg::upb_apb_rsp_type rsp;
    logic [3:0] pin_in, pin_out, pin_oe, digital_in;
    logic [3:0] periph_out = 4'h0;
    logic [3:0] analog_en = 4'h0;
    logic [3:0] ext_val = 4'h0;
    logic [3:0] strb = 4'h1;
    logic [3:0] lat, dir, lvl;
    logic [7:0] v;
    logic [7:0] lfsr = 8'h3d;
    logic [33:0] note;
    logic [33:0] exp_q[$];
    int mismatches = 0;
    int cmp_count = 0;

    always #50 clock = ~clock;

    upb_port_top dut_u (
        .clock(clock),
        .reset_n(reset_n),
        .apb_req(req),
        .apb_rsp(rsp),
        .pin_in(pin_in),
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .periph_out(periph_out),
        .analog_out_en(analog_en),
        .digital_in(digital_in)
    );

    upb_board_model board_u (
        .pin_out(pin_out),
        .pin_oe(pin_oe),
        .ext_val(ext_val),
        .pin_in(pin_in)
    );

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [32:0] seen, input logic [32:0] expv);
        cmp_count++;
        if (seen !== expv) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic conclude();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] expv);
        exp_q.push_back({~wr, expv});
        @(posedge clock);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: strb};
        @(posedge clock);
        req.penable <= 1'b1;
        do @(posedge clock); while (rsp.pready !== 1'b1);
        req <= '0;
    endtask

    task automatic pins(input logic [3:0] po, input logic [3:0] oe);
        check({29'h0, pin_out}, {29'h0, po});
        check({29'h0, pin_oe}, {29'h0, oe});
    endtask

    // answers are matched against the oldest note; write data is not compared
    always @(posedge clock) begin
        if (reset_n && rsp.pready === 1'b1 && req.psel && req.penable) begin
            note = exp_q.pop_front();
            check({rsp.pslverr, note[33] ? rsp.prdata : 32'h0}, note[32:0]);
        end
    end

    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        // reset values: latch source, analog selected, all inputs
        apb(0, upb_pkg::LATCH_OFFSET, 32'h0, 33'h0);
        apb(0, upb_pkg::ANALOG_OFFSET, 32'h0, 33'hf0);
        apb(0, upb_pkg::DIRECTION_OFFSET, 32'h0, 33'hf0);
        apb(0, upb_pkg::ROUTE_OFFSET, 32'h0, 33'h0);
        apb(0, upb_pkg::LEVEL_OFFSET, 32'h0, 33'h0);
        pins(4'h0, 4'h0);
        check({29'h0, digital_in}, 33'h0);
        // outputs drive the latch even with analog selected
        apb(1, upb_pkg::DIRECTION_OFFSET, 32'h0, 33'h0);
        for (int k = 0; k < 4; k++) begin
            v = lfsr;
            lfsr = lfsr_next(lfsr);
            lat = v[7:4];
            apb(1, k[0] ? upb_pkg::LATCH_OFFSET : upb_pkg::LEVEL_OFFSET,
                {24'hffffff, v[7:4], 4'hf}, 33'h0);
            apb(0, upb_pkg::LATCH_OFFSET, 32'h0, {25'h0, lat, 4'h0});
            apb(0, upb_pkg::LEVEL_OFFSET, 32'h0, 33'h0);
            pins(lat, 4'hf);
        end
        // digital mode with mixed directions and a driven board
        apb(1, upb_pkg::ANALOG_OFFSET, 32'h0, 33'h0);
        for (int k = 0; k < 4; k++) begin
            v = lfsr;
            lfsr = lfsr_next(lfsr);
            dir = v[7:4];
            ext_val <= v[3:0];
            lvl = (~dir & lat) | (dir & v[3:0]);
            apb(1, upb_pkg::DIRECTION_OFFSET, {24'h0, dir, 4'h0}, 33'h0);
            repeat (4) @(posedge clock);
            apb(0, upb_pkg::LEVEL_OFFSET, 32'h0, {25'h0, lvl, 4'h0});
            check({29'h0, digital_in}, {29'h0, lvl});
            pins(lat, ~dir);
        end
        // analog on two input pins hides their digital level
        apb(1, upb_pkg::DIRECTION_OFFSET, 32'hf0, 33'h0);
        apb(1, upb_pkg::ANALOG_OFFSET, 32'h50, 33'h0);
        ext_val <= 4'hf;
        repeat (4) @(posedge clock);
        apb(0, upb_pkg::LEVEL_OFFSET, 32'h0, 33'ha0);
        check({29'h0, digital_in}, 33'h0a);
        // peripheral routing and analog output take over from the latch
        apb(1, upb_pkg::DIRECTION_OFFSET, 32'h0, 33'h0);
        apb(1, upb_pkg::ROUTE_OFFSET, 32'h30, 33'h0);
        periph_out <= lfsr[3:0];
        analog_en <= 4'h8;
        repeat (3) @(posedge clock);
        pins({1'b0, lat[2], lfsr[1:0]}, 4'h7);
        // unmapped word is refused and leaves the latch alone
        apb(1, 12'h014, 32'hff, 33'h100000000);
        apb(0, 12'h014, 32'h0, 33'h100000000);
        // a write without the lane 0 strobe is dropped
        strb = 4'h0;
        apb(1, upb_pkg::LATCH_OFFSET, {24'h0, ~lat, 4'h0}, 33'h0);
        strb = 4'h1;
        apb(0, upb_pkg::LATCH_OFFSET, 32'h0, {25'h0, lat, 4'h0});
        // a reset in mid-run hands every pin back to its latch
        analog_en <= 4'h0;
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        apb(0, upb_pkg::ROUTE_OFFSET, 32'h0, 33'h0);
        apb(0, upb_pkg::ANALOG_OFFSET, 32'h0, 33'hf0);
        apb(1, upb_pkg::LATCH_OFFSET, {24'h0, lfsr[7:4], 4'h0}, 33'h0);
        apb(0, upb_pkg::LEVEL_OFFSET, 32'h0, 33'h0);
        pins(lfsr[7:4], 4'h0);
        repeat (2) @(posedge clock);
        conclude();
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #3000000;
        mismatches++;
        conclude();
    end
endmodule
